// ==== sim/frs_partner.sv ====
`timescale 1ns/1ns
module frs_partner #(
  parameter DECEL = 30
) (
  input  wire        clk_i,          // System clock
  input  wire        rst_i,          // Sync reset
  input  wire        run_req_i,      // Bench forward run wish
  input  wire        rev_req_i,      // Bench reverse run wish
  input  wire        pf_req_i,       // Bench power loss wish
  input  wire [15:0] inj_i,          // Fault injection pulse
  input  wire        run_i,          // Block running
  output reg         fwd_run_cmd_o,  // Forward run pin
  output reg         rev_run_cmd_o,  // Reverse run pin
  output reg         power_fail_o,   // Undervoltage pin
  output reg  [15:0] fault_o,        // Fault detector pins
  output wire        zero_speed_o    // Output at 0 Hz
);
  reg [7:0] cnt_r;

  initial {fwd_run_cmd_o, rev_run_cmd_o, power_fail_o, fault_o, cnt_r} = '0;
  assign zero_speed_o = (cnt_r == 8'h00);

  always @(posedge clk_i) begin
    fwd_run_cmd_o <= run_req_i;
    rev_run_cmd_o <= rev_req_i;
    power_fail_o  <= pf_req_i;
    // Detectors report each event as a one-cycle pulse; the block keeps the trip
    if (rst_i) begin
      fault_o <= 16'h0000;
    end else begin
      fault_o <= inj_i;
    end
    // Motor coasts down over DECEL cycles once not driven
    if (run_i) begin
      cnt_r <= 8'(DECEL);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// ==== sim/frs_sequencer_props.sv ====
`timescale 1ns/1ns
module frs_sequencer_chk (
  input wire clk_i,                 // System clock
  input wire rst_i,                 // Sync reset
  input wire ack_o,                 // Bus ack
  input wire fwd_run_cmd_i,         // Forward run pin
  input wire rev_run_cmd_i,         // Reverse run pin
  input wire run_o,                 // Running
  input wire pf_decel_o,            // Power-failure decel
  input wire restart_o,             // Retry restart pulse
  input wire fault_out_o,           // Fault relay
  input wire retry_excess_fault_o,  // Excess trip
  input wire pf_decel_status_o,     // Power-failure status
  input wire retry_active_o         // Retry waiting
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_once: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_restart_gap: assert property (restart_o |=> !restart_o [*3])
    else $error("restart pulse too long or repeated");
  chk_restart_cause: assert property (restart_o |-> $past(retry_active_o))
    else $error("restart without a retry wait");
  chk_restart_clears: assert property (restart_o |-> ##[0:1] (run_o && !fault_out_o))
    else $error("restart did not clear fault and run");
  chk_active_stopped: assert property (retry_active_o |-> !run_o && !pf_decel_status_o)
    else $error("retry active while running");
  chk_pf_status: assert property (pf_decel_o |-> pf_decel_status_o)
    else $error("decel without status");
  chk_excess_trip: assert property
    (retry_excess_fault_o |-> fault_out_o && !run_o && !retry_active_o)
    else $error("excess fault without trip");
  chk_fault_stop: assert property (fault_out_o |-> !run_o)
    else $error("fault output while running");
  chk_run_cause: assert property ($rose(run_o) |-> $past(fwd_run_cmd_i | rev_run_cmd_i, 4))
    else $error("run without run command");

  cov_restart: cover property (restart_o);
  cov_excess: cover property ($rose(retry_excess_fault_o));
  cov_pf: cover property ($rose(pf_decel_status_o));
endmodule

bind frs_sequencer frs_sequencer_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o), .fwd_run_cmd_i(fwd_run_cmd_i),
  .rev_run_cmd_i(rev_run_cmd_i), .run_o(run_o), .pf_decel_o(pf_decel_o),
  .restart_o(restart_o), .fault_out_o(fault_out_o),
  .retry_excess_fault_o(retry_excess_fault_o), .pf_decel_status_o(pf_decel_status_o),
  .retry_active_o(retry_active_o)
);

// ==== sim/tb.sv ====
`timescale 1ns/1ns
`include "frs_defs.vh"
module tb;
  logic        clk, rst, cyc, stb, we, ack, fwd, rev, pf, zs;
  logic        run, pfd, rs, fo, ex, pfs, ra, run_req, rev_req, pf_req;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat;
  logic [15:0] flt, inj, d;
  logic [2:0]  term;
  logic [6:0]  exp_sel = 7'b0011101;
  int          n_fail, comparisons, i, s;

  frs_partner #(.DECEL(30)) ptn (.clk_i(clk), .rst_i(rst), .run_req_i(run_req),
    .rev_req_i(rev_req), .pf_req_i(pf_req), .inj_i(inj), .run_i(run),
    .fwd_run_cmd_o(fwd), .rev_run_cmd_o(rev), .power_fail_o(pf), .fault_o(flt),
    .zero_speed_o(zs));
  frs_sequencer #(.TICK_CYC(4)) uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
    .fwd_run_cmd_i(fwd), .rev_run_cmd_i(rev), .power_fail_i(pf), .fault_i(flt),
    .zero_speed_i(zs), .run_o(run), .pf_decel_o(pfd), .restart_o(rs), .fault_out_o(fo),
    .retry_excess_fault_o(ex), .pf_decel_status_o(pfs), .retry_active_o(ra),
    .out_term_o(term));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task conclude;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task tmo;
    n_fail++;
    $display("[FAIL] %0t wait timed out", $time);
    conclude();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic single cycle; held until ack sampled high
  task wb(input logic w, input logic [7:0] a, input logic [15:0] v);
    int j;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= {16'h0000, v}; sel <= 4'h3;
    j = 0;
    do begin
      @(posedge clk);
      j++;
      if (j > 50) tmo();
    end while (ack !== 1'b1);
    d = rdat[15:0];
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask

  function logic sig(input int k);
    return k == 0 ? run : rs;
  endfunction

  task wt(input int k);
    int j;
    for (j = 0; sig(k) !== 1'b1; j++) begin
      if (j > 300) tmo();
      @(posedge clk);
    end
  endtask

  task pulse(input logic [15:0] f);
    inj <= f;
    @(posedge clk);
    inj <= 16'h0000;
    @(posedge clk);
  endtask

  task boot;
    rst <= 1; run_req <= 0; rev_req <= 0; pf_req <= 0;
    cyc_n(20);
    rst <= 0;
    @(posedge clk);
  endtask

  initial begin
    #1000000;
    tmo();
  end

  initial begin
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h0; wd = 32'h00000000;
    run_req = 0; rev_req = 0; pf_req = 0; inj = 16'h0000; n_fail = 0; comparisons = 0;
    boot();
    for (i = 0; i < 12; i++) begin
      wb(0, 8'(i * 4), 16'h0000);
      chk(d, i == 2 ? `FRS_RST_WAIT : i == 5 ? `FRS_COAST_OFF : 16'h0000);
    end
    wb(1, 8'h2C, 16'hFFFF);
    wb(1, `FRS_ADR_STATUS, 16'hFFFF);
    wb(1, `FRS_ADR_WAIT, 16'h1770);
    wb(0, 8'h2C, 16'h0000); chk(d, 16'h0000);
    wb(0, `FRS_ADR_STATUS, 16'h0000); chk(d, 16'h0000);
    wb(0, `FRS_ADR_WAIT, 16'h0000); chk(d, 16'h1770);
    $display("registers done");
    for (s = 0; s < 7; s++) begin
      boot();
      wb(1, `FRS_ADR_SEL, s == 6 ? 16'h0000 : 16'(s));
      wb(1, `FRS_ADR_LIMIT, s == 6 ? 16'h0000 : 16'h000A);
      run_req <= 1; wt(0);
      pulse(16'h0008); cyc_n(6);
      chk(ra, exp_sel[s]);
      pulse(16'h0040); cyc_n(6);
      chk(ra, s == 0);
      chk(fo, s != 0);
      if (s == 0) begin
        wb(0, `FRS_ADR_STATUS, 16'h0000); chk(d[15:12], 4'h3);
      end
    end
    boot();
    wb(1, `FRS_ADR_SEL, 16'h0004); wb(1, `FRS_ADR_LIMIT, 16'h000A);
    pulse(16'h2000); run_req <= 1; cyc_n(10);
    chk(ra, 1'b0);
    wb(0, `FRS_ADR_STATUS, 16'h0000); chk(d[15:12], 4'hD);
    wb(1, `FRS_ADR_CTRL, 16'h0001); wt(0);
    pulse(16'h2000); cyc_n(6);
    chk(ra, 1'b1);
    $display("selection done");
    boot();
    wb(1, `FRS_ADR_SEL, 16'h0005); wb(1, `FRS_ADR_LIMIT, 16'h0003);
    wb(1, `FRS_ADR_WAIT, 16'h0002); wb(1, `FRS_ADR_TERM_A, 16'h0040);
    wb(1, `FRS_ADR_TERM_B, 16'h00A4);
    rev_req <= 1; wt(0);
    pulse(16'h0001); cyc_n(4);
    chk(ra, 1'b1); chk(fo, 1'b0); chk(term, 3'b001);
    wt(1); cyc_n(3);
    wb(0, `FRS_ADR_STATUS, 16'h0000); chk(d[11:8], 4'h1);
    cyc_n(60);
    wb(0, `FRS_ADR_SUCCESS, 16'h0000); chk(d, 16'h0001);
    wb(0, `FRS_ADR_STATUS, 16'h0000); chk(d[11:8], 4'h0);
    chk(term, 3'b010);
    wb(1, `FRS_ADR_SUCCESS, 16'h0005); wb(0, `FRS_ADR_SUCCESS, 16'h0000);
    chk(d, 16'h0001);
    wb(1, `FRS_ADR_SUCCESS, 16'h0000); wb(0, `FRS_ADR_SUCCESS, 16'h0000);
    chk(d, 16'h0000);
    pulse(16'h0002); cyc_n(6);
    chk(ra, 1'b0); chk(fo, 1'b1);
    $display("retry done");
    boot();
    wb(1, `FRS_ADR_LIMIT, 16'h0065); wb(1, `FRS_ADR_WAIT, 16'h0002);
    run_req <= 1; wt(0);
    pulse(16'h0040); cyc_n(5);
    chk(fo, 1'b1); chk(ra, 1'b1);
    wt(1); cyc_n(8);
    pulse(16'h0040); cyc_n(6);
    chk(ex, 1'b1); chk(ra, 1'b0);
    $display("excess done");
    boot();
    wb(1, `FRS_ADR_PF_MODE, 16'h0001); wb(1, `FRS_ADR_TERM_A, 16'h002E);
    wb(1, `FRS_ADR_TERM_C, 16'h0092); cyc_n(3);
    chk(term, 3'b100);
    run_req <= 1; wt(0);
    pf_req <= 1; cyc_n(6);
    chk(pfs, 1'b1); chk(term, 3'b001);
    pf_req <= 0; cyc_n(60);
    chk(run, 1'b0); chk(pfs, 1'b1);
    run_req <= 0; cyc_n(6);
    run_req <= 1; wt(0); cyc_n(2);
    chk(pfs, 1'b0);
    boot();
    wb(1, `FRS_ADR_PF_MODE, 16'h0002);
    run_req <= 1; wt(0);
    pf_req <= 1; cyc_n(6);
    chk(pfd, 1'b1);
    pf_req <= 0; wt(0);
    run_req <= 0; cyc_n(50);
    pf_req <= 1; cyc_n(8);
    chk(pfs, 1'b0);
    boot();
    wb(1, `FRS_ADR_PF_MODE, 16'h0001); wb(1, `FRS_ADR_COAST, 16'h0005);
    run_req <= 1; wt(0);
    pf_req <= 1; cyc_n(8);
    chk(run, 1'b1); chk(pfs, 1'b0);
    pf_req <= 0; rst <= 1; cyc_n(20);
    rst <= 0; @(posedge clk);
    wb(1, `FRS_ADR_PF_MODE, 16'h0001); cyc_n(20);
    chk(run, 1'b0);
    run_req <= 0; cyc_n(6);
    run_req <= 1; wt(0);
    chk(run, 1'b1);
    $display("power failure done");
    conclude();
  end
endmodule

// ==== src/frs_defs.vh ====
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH

// Register byte offsets
`define FRS_ADR_SEL        8'h00
`define FRS_ADR_LIMIT      8'h04
`define FRS_ADR_WAIT       8'h08
`define FRS_ADR_SUCCESS    8'h0C
`define FRS_ADR_PF_MODE    8'h10
`define FRS_ADR_COAST      8'h14
`define FRS_ADR_TERM_A     8'h18
`define FRS_ADR_TERM_B     8'h1C
`define FRS_ADR_TERM_C     8'h20
`define FRS_ADR_STATUS     8'h24
`define FRS_ADR_CTRL       8'h28

// Reset values
`define FRS_RST_SEL        16'h0000
`define FRS_RST_LIMIT      16'h0000
`define FRS_RST_WAIT       16'h000A
`define FRS_RST_SUCCESS    16'h0000
`define FRS_RST_PF_MODE    16'h0000
`define FRS_RST_COAST      16'h270F
`define FRS_RST_TERM       16'h0000

// Setting codes
`define FRS_COAST_OFF      16'h270F
`define FRS_PF_STAY        16'h0001
`define FRS_PF_CONT        16'h0002
`define FRS_FUNC_PF_POS    16'h002E
`define FRS_FUNC_PF_NEG    16'h0092
`define FRS_FUNC_RT_POS    16'h0040
`define FRS_FUNC_RT_NEG    16'h00A4
`define FRS_LIM_MAX_A      16'h000A
`define FRS_LIM_MIN_B      16'h0065
`define FRS_LIM_MAX_B      16'h006E
`define FRS_LIM_OFS_B      16'h0064

// Retry eligibility masks per fault selection
`define FRS_MASK_SEL0      16'hFFFF
`define FRS_MASK_SEL1      16'h0007
`define FRS_MASK_SEL2      16'h0038
`define FRS_MASK_SEL3      16'h003F
`define FRS_MASK_SEL4      16'hF33F
`define FRS_MASK_SEL5      16'h0005

// Fault bit positions
`define FRS_BIT_PE         4'hD

// Status register field positions
`define FRS_ST_STATE_LO    0
`define FRS_ST_PF          4
`define FRS_ST_RETRY       5
`define FRS_ST_EXCESS      6
`define FRS_ST_FAULT       7
`define FRS_ST_FCNT_LO     8
`define FRS_ST_CODE_LO     12

// Control register fields
`define FRS_CTRL_RESET     0

// Timing: wait-time unit is 0.1 s
`define FRS_TICK_MS        100
`define FRS_CLK_KHZ        50000

`endif

// ==== src/frs_sequencer.v ====
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "frs_defs.vh"
module frs_sequencer #(
  parameter TICK_CYC = `FRS_TICK_MS * `FRS_CLK_KHZ,
  parameter PRE_W    = 23
) (
  input  wire        clk_i,                  // 50 MHz clock
  input  wire        rst_i,                  // Sync reset, high
  input  wire        cyc_i,                  // Wishbone cycle
  input  wire        stb_i,                  // Wishbone strobe
  input  wire        we_i,                   // Wishbone write
  input  wire [7:0]  adr_i,                  // Wishbone byte address
  input  wire [3:0]  sel_i,                  // Wishbone byte lanes
  input  wire [31:0] dat_i,                  // Wishbone write data
  output wire [31:0] dat_o,                  // Wishbone read data
  output wire        ack_o,                  // Wishbone ack
  input  wire        fwd_run_cmd_i,          // Forward run pin
  input  wire        rev_run_cmd_i,          // Reverse run pin
  input  wire        power_fail_i,           // Undervoltage detector pin
  input  wire [15:0] fault_i,                // Fault detector pins
  input  wire        zero_speed_i,           // Output reached 0 Hz
  output reg         run_o,                  // Drive allowed to run
  output reg         pf_decel_o,             // Bus-regulated deceleration
  output reg         restart_o,              // Retry restart pulse
  output reg         fault_out_o,            // Fault relay
  output reg         retry_excess_fault_o,   // Retry count excess trip
  output reg         pf_decel_status_o,      // Power-failure decel status
  output reg         retry_active_o,         // Retry in progress
  output reg  [2:0]  out_term_o              // Assigned output terminals
);
  localparam ST_STOP = 3'd0;
  localparam ST_RUN  = 3'd1;
  localparam ST_PFD  = 3'd2;
  localparam ST_PFS  = 3'd3;
  localparam ST_WAIT = 3'd4;
  localparam ST_TRIP = 3'd5;

  localparam [PRE_W-1:0] TICK_LAST = TICK_CYC - 1;

  wire        fwd_s;
  wire        rev_s;
  wire        pf_s;
  wire [15:0] flt_s;

  frs_sync #(.W(19)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({fwd_run_cmd_i, rev_run_cmd_i, power_fail_i, fault_i}),
    .q_o   ({fwd_s, rev_s, pf_s, flt_s})
  );

  reg [15:0] sel_r;
  reg [15:0] limit_r;
  reg [15:0] wait_r;
  reg [15:0] succ_r;
  reg [15:0] pfmode_r;
  reg [15:0] coast_r;
  reg [15:0] term_r [0:2];
  reg        ack_r;
  reg [31:0] rdat_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg        lock_r;
  reg        boot_r;
  reg        por_r;
  reg        retried_r;
  reg [3:0]  fcnt_r;
  reg [3:0]  code_r;
  reg [1:0]  settle_r;
  reg        excess_r;
  reg [PRE_W-1:0] pre_r;
  reg        tick_r;

  wire run_req = fwd_s | rev_s;
  wire acc     = cyc_i & stb_i & ~ack_r;
  wire wr      = acc & we_i;
  wire rst_cmd = wr && (adr_i == `FRS_ADR_CTRL) && sel_i[0] && dat_i[`FRS_CTRL_RESET];
  wire any_flt = |flt_s;

  // Byte-lane merge for 16-bit registers
  function [15:0] lanes;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      lanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // Prescaler for the 0.1 s time unit
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_r  <= {PRE_W{1'b0}};
      tick_r <= 1'b0;
    end else begin
      tick_r <= (pre_r == TICK_LAST);
      pre_r  <= (pre_r == TICK_LAST) ? {PRE_W{1'b0}} : pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // Fault eligibility
  reg [15:0] mask;
  always @* begin
    case (sel_r)
      16'h0000: mask = `FRS_MASK_SEL0;
      16'h0001: mask = `FRS_MASK_SEL1;
      16'h0002: mask = `FRS_MASK_SEL2;
      16'h0003: mask = `FRS_MASK_SEL3;
      16'h0004: mask = `FRS_MASK_SEL4;
      16'h0005: mask = `FRS_MASK_SEL5;
      default:  mask = 16'h0000;
    endcase
  end

  // Lowest-numbered active fault is the one recorded
  reg [3:0] first_idx;
  integer   i;
  always @* begin
    first_idx = 4'h0;
    for (i = 15; i >= 0; i = i - 1) begin
      if (flt_s[i]) begin
        first_idx = i[3:0];
      end
    end
  end

  // Allowed retries from the count setting
  reg [3:0] n_retry;
  reg       out_in_retry;
  wire [15:0] lim_diff = limit_r - `FRS_LIM_OFS_B;
  always @* begin
    n_retry      = 4'h0;
    out_in_retry = 1'b0;
    if (limit_r >= 16'h0001 && limit_r <= `FRS_LIM_MAX_A) begin
      n_retry = limit_r[3:0];
    end else if (limit_r >= `FRS_LIM_MIN_B && limit_r <= `FRS_LIM_MAX_B) begin
      n_retry      = lim_diff[3:0];
      out_in_retry = 1'b1;
    end
  end
  wire        elig = (n_retry != 4'h0) && mask[first_idx]
                     && !(first_idx == `FRS_BIT_PE && por_r);
  wire        exceed = (fcnt_r >= n_retry);

  // Timers
  wire [15:0] wcnt;
  wire [15:0] scnt;
  wire [15:0] wait_eff = (wait_r == 16'h0000) ? 16'h0001 : wait_r;
  frs_tick_cnt #(.W(16)) u_wait (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (state_r != ST_WAIT),
    .tick_i (tick_r),
    .cnt_o  (wcnt)
  );
  frs_tick_cnt #(.W(16)) u_succ (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  ((state_r != ST_RUN) || !retried_r),
    .tick_i (tick_r),
    .cnt_o  (scnt)
  );
  wire wait_done = (wcnt >= wait_eff);
  wire success   = (state_r == ST_RUN) && retried_r &&
                   ({2'b00, scnt} > {wait_eff, 2'b00});

  wire pf_active = ((pfmode_r == `FRS_PF_STAY) || (pfmode_r == `FRS_PF_CONT))
                   && (coast_r == `FRS_COAST_OFF);
  wire can_start = run_req && (!lock_r || (boot_r && pfmode_r != `FRS_PF_STAY));

  // Sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_STOP: begin
        if (any_flt) begin
          state_nxt = ST_TRIP;
        end else if (can_start) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_flt) begin
          state_nxt = (elig && !exceed) ? ST_WAIT : ST_TRIP;
        end else if (pf_s && pf_active) begin
          state_nxt = ST_PFD;
        end else if (!run_req) begin
          state_nxt = ST_STOP;
        end
      end
      ST_PFD: begin
        if (any_flt) begin
          state_nxt = (elig && !exceed) ? ST_WAIT : ST_TRIP;
        end else if (!pf_s && pfmode_r == `FRS_PF_CONT) begin
          state_nxt = ST_RUN;
        end else if (zero_speed_i) begin
          state_nxt = ST_PFS;
        end
      end
      ST_PFS: begin
        if (any_flt) begin
          state_nxt = ST_TRIP;
        end else if (run_req && !lock_r) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (|(flt_s & ~mask)) begin
          state_nxt = ST_TRIP;
        end else if (wait_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_TRIP: begin
        if (rst_cmd) begin
          state_nxt = ST_STOP;
        end
      end
      default: state_nxt = ST_STOP;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r   <= ST_STOP;
      lock_r    <= 1'b1;
      boot_r    <= 1'b1;
      por_r     <= 1'b1;
      retried_r <= 1'b0;
      fcnt_r    <= 4'h0;
      code_r    <= 4'h0;
      excess_r  <= 1'b0;
      restart_o <= 1'b0;
      settle_r  <= 2'b00;
    end else begin
      state_r   <= state_nxt;
      restart_o <= (state_r == ST_WAIT) && (state_nxt == ST_RUN);
      settle_r  <= {settle_r[0], 1'b1};
      // Synchronised pins read low for two edges after reset
      if (!run_req && settle_r[1]) begin
        lock_r <= 1'b0;
        boot_r <= 1'b0;
      end
      if (state_r == ST_PFD && state_nxt == ST_PFS) begin
        lock_r <= 1'b1;
      end
      if (state_nxt == ST_RUN) begin
        boot_r <= 1'b0;
        por_r  <= 1'b0;
      end
      // Record the fault that leaves RUN, PFD, STOP or PFS, not one raised in WAIT
      if ((state_r == ST_RUN || state_r == ST_PFD || state_r == ST_STOP
           || state_r == ST_PFS) && any_flt) begin
        code_r <= first_idx;
        excess_r <= (state_r == ST_RUN || state_r == ST_PFD) && elig && exceed;
      end
      if (state_r == ST_WAIT && state_nxt == ST_RUN) begin
        fcnt_r    <= fcnt_r + 4'h1;
        retried_r <= 1'b1;
      end else if (success) begin
        fcnt_r    <= 4'h0;
        retried_r <= 1'b0;
      end
      if (rst_cmd && state_r == ST_TRIP) begin
        fcnt_r    <= 4'h0;
        excess_r  <= 1'b0;
        retried_r <= 1'b0;
      end
    end
  end

  // Outputs
  wire pf_stat = (state_r == ST_PFD) || (state_r == ST_PFS);
  wire rt_act  = (state_r == ST_WAIT);
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_o                <= 1'b0;
      pf_decel_o           <= 1'b0;
      fault_out_o          <= 1'b0;
      retry_excess_fault_o <= 1'b0;
      pf_decel_status_o    <= 1'b0;
      retry_active_o       <= 1'b0;
    end else begin
      run_o                <= (state_r == ST_RUN);
      pf_decel_o           <= (state_r == ST_PFD);
      fault_out_o          <= (state_r == ST_TRIP) || (rt_act && out_in_retry);
      retry_excess_fault_o <= (state_r == ST_TRIP) && excess_r;
      pf_decel_status_o    <= pf_stat;
      retry_active_o       <= rt_act;
    end
  end

  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1) begin : g_term
      always @(posedge clk_i) begin
        if (rst_i) begin
          out_term_o[t] <= 1'b0;
        end else begin
          case (term_r[t])
            `FRS_FUNC_PF_POS: out_term_o[t] <= pf_stat;
            `FRS_FUNC_PF_NEG: out_term_o[t] <= ~pf_stat;
            `FRS_FUNC_RT_POS: out_term_o[t] <= rt_act;
            `FRS_FUNC_RT_NEG: out_term_o[t] <= ~rt_act;
            default:          out_term_o[t] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Wishbone slave, ack one cycle after request
  wire succ_wr = wr && (adr_i == `FRS_ADR_SUCCESS);
  wire [15:0] succ_wval = lanes(succ_r, dat_i, sel_i);
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      sel_r    <= `FRS_RST_SEL;
      limit_r  <= `FRS_RST_LIMIT;
      wait_r   <= `FRS_RST_WAIT;
      succ_r   <= `FRS_RST_SUCCESS;
      pfmode_r <= `FRS_RST_PF_MODE;
      coast_r  <= `FRS_RST_COAST;
      term_r[0] <= `FRS_RST_TERM;
      term_r[1] <= `FRS_RST_TERM;
      term_r[2] <= `FRS_RST_TERM;
    end else begin
      ack_r <= acc;
      if (wr) begin
        case (adr_i)
          `FRS_ADR_SEL:     sel_r     <= lanes(sel_r, dat_i, sel_i);
          `FRS_ADR_LIMIT:   limit_r   <= lanes(limit_r, dat_i, sel_i);
          `FRS_ADR_WAIT:    wait_r    <= lanes(wait_r, dat_i, sel_i);
          `FRS_ADR_PF_MODE: pfmode_r  <= lanes(pfmode_r, dat_i, sel_i);
          `FRS_ADR_COAST:   coast_r   <= lanes(coast_r, dat_i, sel_i);
          `FRS_ADR_TERM_A:  term_r[0] <= lanes(term_r[0], dat_i, sel_i);
          `FRS_ADR_TERM_B:  term_r[1] <= lanes(term_r[1], dat_i, sel_i);
          `FRS_ADR_TERM_C:  term_r[2] <= lanes(term_r[2], dat_i, sel_i);
          default: ;
        endcase
      end
      // A same-cycle clear is applied first, then the increment
      if (success) begin
        succ_r <= ((succ_wr && succ_wval == 16'h0000) ? 16'h0000 : succ_r) + 16'h0001;
      end else if (succ_wr && succ_wval == 16'h0000) begin
        succ_r <= 16'h0000;
      end
      if (acc && !we_i) begin
        case (adr_i)
          `FRS_ADR_SEL:     rdat_r <= {16'h0000, sel_r};
          `FRS_ADR_LIMIT:   rdat_r <= {16'h0000, limit_r};
          `FRS_ADR_WAIT:    rdat_r <= {16'h0000, wait_r};
          `FRS_ADR_SUCCESS: rdat_r <= {16'h0000, succ_r};
          `FRS_ADR_PF_MODE: rdat_r <= {16'h0000, pfmode_r};
          `FRS_ADR_COAST:   rdat_r <= {16'h0000, coast_r};
          `FRS_ADR_TERM_A:  rdat_r <= {16'h0000, term_r[0]};
          `FRS_ADR_TERM_B:  rdat_r <= {16'h0000, term_r[1]};
          `FRS_ADR_TERM_C:  rdat_r <= {16'h0000, term_r[2]};
          `FRS_ADR_STATUS:  rdat_r <= {16'h0000, code_r, fcnt_r, fault_out_o,
                                       excess_r, rt_act, pf_stat, 1'b0, state_r};
          default:          rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;
endmodule

// ==== src/frs_sync.v ====
`timescale 1ns/1ns
module frs_sync #(
  parameter W = 1
) (
  input  wire         clk_i,   // System clock
  input  wire         rst_i,   // Sync reset
  input  wire [W-1:0] d_i,     // Asynchronous inputs
  output wire [W-1:0] q_o      // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

// ==== src/frs_tick_cnt.v ====
`timescale 1ns/1ns
module frs_tick_cnt #(
  parameter W = 16
) (
  input  wire         clk_i,   // System clock
  input  wire         rst_i,   // Sync reset
  input  wire         clr_i,   // Restart count from zero
  input  wire         tick_i,  // Time-unit tick
  output reg  [W-1:0] cnt_o    // Elapsed ticks, saturating
);
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_o <= {W{1'b0}};
    end else if (tick_i && (cnt_o != {W{1'b1}})) begin
      cnt_o <= cnt_o + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
